// ### swx_regs.svh
// offsets, field values, reset values and write masks of the extended config space
// Notes on behaviour
// RULE_01: first extended capability header sits at config offset 100h.
// RULE_02: all later extended capabilities sit above 0FFh, outside the legacy header.
// RULE_03: header at 100h returns id 0001h and next pointer 140h.
// RULE_04: channel capability 2 reports channel arbitration table offset 3.
// RULE_05: second channel resource capability reports port arbitration table offset 6.
// RULE_06: header at 220h returns id 000Dh and next pointer 000h.
// RULE_07: header at 230h returns id 0018h; 234h holds latency values and scales.
// RULE_08: vendor_identifier is read-only to config writes, reloadable by SMBus or EEPROM.
// RULE_09: reserved offsets read zero; writes there are ignored.
`ifndef SWX_REGS_SVH
`define SWX_REGS_SVH

`define SWX_OFF_VID 12'h000
`define SWX_OFF_AER_HDR 12'h100
`define SWX_OFF_UE_STAT 12'h104
`define SWX_OFF_UE_MASK 12'h108
`define SWX_OFF_UE_SEV 12'h10C
`define SWX_OFF_CE_STAT 12'h110
`define SWX_OFF_CE_MASK 12'h114
`define SWX_OFF_AER_CTL 12'h118
`define SWX_OFF_HLOG0 12'h11C
`define SWX_OFF_HLOG1 12'h120
`define SWX_OFF_HLOG2 12'h124
`define SWX_OFF_HLOG3 12'h128
`define SWX_OFF_AER_RSVD 12'h12C
`define SWX_OFF_VC_HDR 12'h140
`define SWX_OFF_VC_CAP1 12'h144
`define SWX_OFF_VC_CAP2 12'h148
`define SWX_OFF_VC_CTL 12'h14C
`define SWX_OFF_R0_CAP 12'h150
`define SWX_OFF_R0_CTL 12'h154
`define SWX_OFF_R0_STS 12'h158
`define SWX_OFF_R1_CAP 12'h15C
`define SWX_OFF_R1_CTL 12'h160
`define SWX_OFF_R1_STS 12'h164
`define SWX_OFF_TBL_LO 12'h170
`define SWX_OFF_TBL_HI 12'h1FC
`define SWX_OFF_PB_HDR 12'h20C
`define SWX_OFF_PB_SEL 12'h210
`define SWX_OFF_PB_DATA 12'h214
`define SWX_OFF_PB_CAP 12'h218
`define SWX_OFF_ACS_HDR 12'h220
`define SWX_OFF_ACS_CC 12'h224
`define SWX_OFF_EGR 12'h228
`define SWX_OFF_LTR_HDR 12'h230
`define SWX_OFF_LTR_LAT 12'h234

// capability headers: next pointer [31:20], version [19:16], id [15:0]
`define SWX_AER_HDR_VAL 32'h1401_0001
`define SWX_VC_HDR_VAL 32'h20C1_0002
`define SWX_PB_HDR_VAL 32'h2201_0004
`define SWX_ACS_HDR_VAL 32'h0001_000D
`define SWX_LTR_HDR_VAL 32'h0001_0018
`define SWX_EXT_BASE 12'h0FF
`define SWX_NEXT_AER 12'h140
`define SWX_NEXT_VC 12'h20C

// fixed capability words; table offset fields at [31:24]
`define SWX_VC_CAP1_VAL 32'h0000_0001
`define SWX_VC_CAP2_VAL 32'h0300_0001
`define SWX_R0_CAP_VAL 32'h0400_0001
`define SWX_R1_CAP_VAL 32'h0600_0001
`define SWX_PB_CAP_VAL 32'h0000_0001
`define SWX_PB_DATA0 32'h0000_0000
`define SWX_ACS_CAP_VAL 16'h001F

// reset values (vendor_identifier default is arbitrary)
`define SWX_VID_RST 16'h1A2B
`define SWX_UE_SEV_RST 32'h0000_0000
`define SWX_R0_CTL_RST 32'h8000_0001
`define SWX_R1_CTL_RST 32'h0100_0000

// implemented status bits and writable bits
`define SWX_UE_IMPL 32'h03FF_F030
`define SWX_CE_IMPL 32'h0000_31C1
`define SWX_AER_CTL_WMASK 32'h0000_0140
`define SWX_VC_CTL_WMASK 32'h0000_000F
`define SWX_R0_CTL_WMASK 32'h0000_00FE
`define SWX_R1_CTL_WMASK 32'h8700_00FE
`define SWX_PB_SEL_WMASK 32'h0000_00FF
`define SWX_ACS_CTL_WMASK 32'h001F_0000
`define SWX_EGR_WMASK 32'h0000_0007
`define SWX_LTR_WMASK 32'h1FFF_1FFF
`define SWX_TBL_STS_BIT 16
`define SWX_TBL_BASE_IDX 6'h1C
`define SWX_TBL_DEPTH 36

`endif

// ### swx_pkg.sv
// types shared by the extended config space modules
package swx_pkg;
  typedef enum logic [1:0] {
    SWX_ST_IDLE = 2'b01,
    SWX_ST_RESP = 2'b10
  } swx_state_e;
  typedef logic [31:0] swx_word_t;
  typedef logic [11:0] swx_addr_t;
endpackage

// ### swx_tbl_if.sv
// carrier between the register file and the arbitration table memory
`timescale 1ns/1ns
`default_nettype none
interface swx_tbl_if;
  logic en;
  logic we;
  logic [5:0] addr;
  logic [3:0] be;
  swx_pkg::swx_word_t wdata;
  swx_pkg::swx_word_t rdata;
  modport ctl (output en, output we, output addr, output be, output wdata, input rdata);
  modport mem (input en, input we, input addr, input be, input wdata, output rdata);
endinterface
`default_nettype wire

// ### swx_sticky.sv
// sticky error status word, write one to clear, set beats clear
`timescale 1ns/1ns
`default_nettype none
module swx_sticky #(
  parameter logic [31:0] IMPL = 32'hFFFF_FFFF
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] set_in,
  input wire logic [31:0] clr_in,
  output logic [31:0] q_out
);
  logic [31:0] q_r;
  logic [31:0] q_nxt;

  // clear first, then set so a coincident event survives
  assign q_nxt = ((q_r & ~clr_in) | set_in) & IMPL;
  assign q_out = q_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= 32'h0000_0000;
    end else begin
      q_r <= q_nxt;
    end
  end

  chk_sticky_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> ((q_r & $past(set_in & IMPL)) == $past(set_in & IMPL)))
    else $error("status event lost");
endmodule
`default_nettype wire

// ### swx_tbl_mem.sv
// arbitration tables, byte writable, registered read data
`timescale 1ns/1ns
`default_nettype none
`include "swx_regs.svh"
module swx_tbl_mem (
  input wire logic clk_in,
  input wire logic rst_n_in,
  swx_tbl_if.mem tbl
);
  logic [31:0] mem_r [0:`SWX_TBL_DEPTH-1];
  logic [31:0] rdata_r;

  // table words, cleared at reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `SWX_TBL_DEPTH; i++) begin
        mem_r[i] <= 32'h0000_0000;
      end
    end else if (tbl.en && tbl.we) begin
      for (int b = 0; b < 4; b++) begin
        if (tbl.be[b]) begin
          mem_r[tbl.addr][8*b +: 8] <= tbl.wdata[8*b +: 8];
        end
      end
    end
  end

  // read port, value held until the next access
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (tbl.en) begin
      rdata_r <= mem_r[tbl.addr];
    end
  end

  assign tbl.rdata = rdata_r;
endmodule
`default_nettype wire

// ### swx_ecfg.sv
// extended configuration space register bank of one switch port
`timescale 1ns/1ns
`default_nettype none
`include "swx_regs.svh"
module swx_ecfg (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CFG_REQ_IN,
  input wire logic CFG_WR_IN,
  input wire logic [11:0] CFG_ADDR_IN,
  input wire logic [3:0] CFG_BE_IN,
  input wire logic [31:0] CFG_WDATA_IN,
  output logic CFG_ACK_OUT,
  output logic [31:0] CFG_RDATA_OUT,
  input wire logic VID_LOAD_IN,
  input wire logic [15:0] VID_LOAD_DATA_IN,
  input wire logic [31:0] UE_EVENT_IN,
  input wire logic [31:0] CE_EVENT_IN,
  input wire logic [127:0] HDR_LOG_IN,
  output logic ERR_FATAL_OUT,
  output logic ERR_NONFATAL_OUT,
  output logic ERR_COR_OUT,
  output logic [15:0] ACS_CTRL_OUT,
  output logic [7:0] EGRESS_VEC_OUT,
  output logic CH1_ENABLE_OUT,
  output logic [31:0] LTR_LIMITS_OUT
);
  swx_pkg::swx_state_e state_r;
  swx_pkg::swx_state_e state_nxt;
  swx_pkg::swx_addr_t wa;
  swx_pkg::swx_addr_t addr_r;
  logic taken;
  logic wr;
  logic [31:0] bmask;
  logic [15:0] vid_r;
  logic [31:0] ue_stat;
  logic [31:0] ce_stat;
  logic [31:0] ue_mask_r;
  logic [31:0] ue_sev_r;
  logic [31:0] ce_mask_r;
  logic [31:0] aer_ctl_r;
  logic [127:0] hlog_r;
  logic [31:0] vc_ctl_r;
  logic [31:0] r0_ctl_r;
  logic [31:0] r1_ctl_r;
  logic [31:0] pb_sel_r;
  logic [31:0] acs_ctl_r;
  logic [31:0] egr_r;
  logic [31:0] ltr_r;
  logic tbl_sts_r;
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;
  logic sel_tbl_r;
  logic in_tbl;
  logic [31:0] ue_clr;
  logic [31:0] ce_clr;
  logic ue_new;
  logic log_take;
  logic fatal_r;
  logic nonfatal_r;
  logic cor_r;

  swx_tbl_if tbl ();

  // masked write of the lanes the request enables
  function automatic logic [31:0] upd(input logic [31:0] old, input logic [31:0] wd,
                                      input logic [31:0] wm, input logic [31:0] bm);
    logic [31:0] m;
    m = wm & bm;
    upd = (old & ~m) | (wd & m);
  endfunction

  // request decode
  assign taken = CFG_REQ_IN && (state_r == swx_pkg::SWX_ST_IDLE);
  assign wr = taken && CFG_WR_IN;
  assign wa = {CFG_ADDR_IN[11:2], 2'b00};
  assign bmask = {{8{CFG_BE_IN[3]}}, {8{CFG_BE_IN[2]}}, {8{CFG_BE_IN[1]}}, {8{CFG_BE_IN[0]}}};
  assign in_tbl = (wa >= `SWX_OFF_TBL_LO) && (wa <= `SWX_OFF_TBL_HI);

  // request and answer sequencing
  always_comb begin
    case (state_r)
      swx_pkg::SWX_ST_IDLE: state_nxt = taken ? swx_pkg::SWX_ST_RESP : swx_pkg::SWX_ST_IDLE;
      swx_pkg::SWX_ST_RESP: state_nxt = swx_pkg::SWX_ST_IDLE;
      default: state_nxt = swx_pkg::SWX_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_r <= swx_pkg::SWX_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // arbitration table access
  assign tbl.en = taken && in_tbl;
  assign tbl.we = CFG_WR_IN;
  assign tbl.addr = 6'(wa[7:2] - `SWX_TBL_BASE_IDX);
  assign tbl.be = CFG_BE_IN;
  assign tbl.wdata = CFG_WDATA_IN;

  swx_tbl_mem u_tbl (
    .clk_in(CLK_IN),
    .rst_n_in(NRST_IN),
    .tbl(tbl.mem)
  );

  // error status words, cleared by writing ones
  assign ue_clr = (wr && wa == `SWX_OFF_UE_STAT) ? (CFG_WDATA_IN & bmask) : 32'h0000_0000;
  assign ce_clr = (wr && wa == `SWX_OFF_CE_STAT) ? (CFG_WDATA_IN & bmask) : 32'h0000_0000;

  swx_sticky #(.IMPL(`SWX_UE_IMPL)) u_ue (
    .clk_in(CLK_IN),
    .rst_n_in(NRST_IN),
    .set_in(UE_EVENT_IN),
    .clr_in(ue_clr),
    .q_out(ue_stat)
  );

  swx_sticky #(.IMPL(`SWX_CE_IMPL)) u_ce (
    .clk_in(CLK_IN),
    .rst_n_in(NRST_IN),
    .set_in(CE_EVENT_IN),
    .clr_in(ce_clr),
    .q_out(ce_stat)
  );

  // header log grabs the first unmasked uncorrectable error
  assign ue_new = |(UE_EVENT_IN & `SWX_UE_IMPL & ~ue_mask_r);
  assign log_take = ue_new && ((ue_stat & ~ue_mask_r) == 32'h0000_0000);

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hlog_r <= 128'h0;
    end else if (log_take) begin
      hlog_r <= HDR_LOG_IN;
    end
  end

  // vendor_identifier: only the load path changes it, config writes never do
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      vid_r <= `SWX_VID_RST;
    end else if (VID_LOAD_IN) begin
      vid_r <= VID_LOAD_DATA_IN; // RULE_08
    end
  end

  // error reporting control words
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ue_mask_r <= 32'h0000_0000;
      ue_sev_r <= `SWX_UE_SEV_RST;
      ce_mask_r <= 32'h0000_0000;
      aer_ctl_r <= 32'h0000_0000;
    end else if (wr) begin
      if (wa == `SWX_OFF_UE_MASK) ue_mask_r <= upd(ue_mask_r, CFG_WDATA_IN, `SWX_UE_IMPL, bmask);
      if (wa == `SWX_OFF_UE_SEV) ue_sev_r <= upd(ue_sev_r, CFG_WDATA_IN, `SWX_UE_IMPL, bmask);
      if (wa == `SWX_OFF_CE_MASK) ce_mask_r <= upd(ce_mask_r, CFG_WDATA_IN, `SWX_CE_IMPL, bmask);
      if (wa == `SWX_OFF_AER_CTL) begin
        aer_ctl_r <= upd(aer_ctl_r, CFG_WDATA_IN, `SWX_AER_CTL_WMASK, bmask);
      end
    end
  end

  // channel control words
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      vc_ctl_r <= 32'h0000_0000;
      r0_ctl_r <= `SWX_R0_CTL_RST;
      r1_ctl_r <= `SWX_R1_CTL_RST;
    end else if (wr) begin
      if (wa == `SWX_OFF_VC_CTL) vc_ctl_r <= upd(vc_ctl_r, CFG_WDATA_IN, `SWX_VC_CTL_WMASK, bmask);
      if (wa == `SWX_OFF_R0_CTL) r0_ctl_r <= upd(r0_ctl_r, CFG_WDATA_IN, `SWX_R0_CTL_WMASK, bmask);
      if (wa == `SWX_OFF_R1_CTL) r1_ctl_r <= upd(r1_ctl_r, CFG_WDATA_IN, `SWX_R1_CTL_WMASK, bmask);
    end
  end

  // table status: a table write marks it stale, a load command clears it
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tbl_sts_r <= 1'b0;
    end else if (wr && in_tbl) begin
      tbl_sts_r <= 1'b1;
    end else if (wr && wa == `SWX_OFF_VC_CTL && CFG_BE_IN[0] && CFG_WDATA_IN[0]) begin
      tbl_sts_r <= 1'b0;
    end
  end

  // power budget, access control and latency words
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pb_sel_r <= 32'h0000_0000;
      acs_ctl_r <= 32'h0000_0000;
      egr_r <= 32'h0000_0000;
      ltr_r <= 32'h0000_0000;
    end else if (wr) begin
      if (wa == `SWX_OFF_PB_SEL) pb_sel_r <= upd(pb_sel_r, CFG_WDATA_IN, `SWX_PB_SEL_WMASK, bmask);
      if (wa == `SWX_OFF_ACS_CC) begin
        acs_ctl_r <= upd(acs_ctl_r, CFG_WDATA_IN, `SWX_ACS_CTL_WMASK, bmask);
      end
      if (wa == `SWX_OFF_EGR) egr_r <= upd(egr_r, CFG_WDATA_IN, `SWX_EGR_WMASK, bmask);
      if (wa == `SWX_OFF_LTR_LAT) begin
        ltr_r <= upd(ltr_r, CFG_WDATA_IN, `SWX_LTR_WMASK, bmask); // RULE_07
      end
    end
  end

  // read selection, everything unlisted reads zero
  assign rd_mux =
    (wa == `SWX_OFF_VID) ? {16'h0000, vid_r} : // RULE_08
    (wa == `SWX_OFF_AER_HDR) ? `SWX_AER_HDR_VAL : // RULE_01
    (wa == `SWX_OFF_UE_STAT) ? ue_stat :
    (wa == `SWX_OFF_UE_MASK) ? ue_mask_r :
    (wa == `SWX_OFF_UE_SEV) ? ue_sev_r :
    (wa == `SWX_OFF_CE_STAT) ? ce_stat :
    (wa == `SWX_OFF_CE_MASK) ? ce_mask_r :
    (wa == `SWX_OFF_AER_CTL) ? aer_ctl_r :
    (wa == `SWX_OFF_HLOG0) ? hlog_r[31:0] :
    (wa == `SWX_OFF_HLOG1) ? hlog_r[63:32] :
    (wa == `SWX_OFF_HLOG2) ? hlog_r[95:64] :
    (wa == `SWX_OFF_HLOG3) ? hlog_r[127:96] :
    (wa == `SWX_OFF_VC_HDR) ? `SWX_VC_HDR_VAL : // RULE_02
    (wa == `SWX_OFF_VC_CAP1) ? `SWX_VC_CAP1_VAL :
    (wa == `SWX_OFF_VC_CAP2) ? `SWX_VC_CAP2_VAL : // RULE_04
    (wa == `SWX_OFF_VC_CTL) ? (vc_ctl_r | (32'(tbl_sts_r) << `SWX_TBL_STS_BIT)) :
    (wa == `SWX_OFF_R0_CAP) ? `SWX_R0_CAP_VAL :
    (wa == `SWX_OFF_R0_CTL) ? r0_ctl_r :
    (wa == `SWX_OFF_R1_CAP) ? `SWX_R1_CAP_VAL : // RULE_05
    (wa == `SWX_OFF_R1_CTL) ? r1_ctl_r :
    (wa == `SWX_OFF_PB_HDR) ? `SWX_PB_HDR_VAL :
    (wa == `SWX_OFF_PB_SEL) ? pb_sel_r :
    (wa == `SWX_OFF_PB_DATA) ? ((pb_sel_r == 32'h0000_0000) ? `SWX_PB_DATA0 : 32'h0000_0000) :
    (wa == `SWX_OFF_PB_CAP) ? `SWX_PB_CAP_VAL :
    (wa == `SWX_OFF_ACS_HDR) ? `SWX_ACS_HDR_VAL : // RULE_06
    (wa == `SWX_OFF_ACS_CC) ? (acs_ctl_r | {16'h0000, `SWX_ACS_CAP_VAL}) :
    (wa == `SWX_OFF_EGR) ? egr_r :
    (wa == `SWX_OFF_LTR_HDR) ? `SWX_LTR_HDR_VAL : // RULE_07
    (wa == `SWX_OFF_LTR_LAT) ? ltr_r :
    32'h0000_0000; // RULE_09

  // answer capture
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rdata_r <= 32'h0000_0000;
      addr_r <= 12'h000;
      sel_tbl_r <= 1'b0;
    end else if (taken) begin
      rdata_r <= rd_mux;
      addr_r <= wa;
      sel_tbl_r <= in_tbl;
    end
  end

  assign CFG_ACK_OUT = (state_r == swx_pkg::SWX_ST_RESP);
  assign CFG_RDATA_OUT = sel_tbl_r ? tbl.rdata : rdata_r;

  // error summary outputs
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fatal_r <= 1'b0;
      nonfatal_r <= 1'b0;
      cor_r <= 1'b0;
    end else begin
      fatal_r <= |(ue_stat & ~ue_mask_r & ue_sev_r);
      nonfatal_r <= |(ue_stat & ~ue_mask_r & ~ue_sev_r);
      cor_r <= |(ce_stat & ~ce_mask_r);
    end
  end

  assign ERR_FATAL_OUT = fatal_r;
  assign ERR_NONFATAL_OUT = nonfatal_r;
  assign ERR_COR_OUT = cor_r;
  assign ACS_CTRL_OUT = acs_ctl_r[31:16];
  assign EGRESS_VEC_OUT = egr_r[7:0];
  assign CH1_ENABLE_OUT = r1_ctl_r[31];
  assign LTR_LIMITS_OUT = ltr_r;

  // checks on the answered reads, register writes, the load path, error logging and table status
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  chk_ack_one_cycle: assert property (taken |=> CFG_ACK_OUT ##1 !CFG_ACK_OUT)
    else $error("answer not exactly one cycle after request");
  chk_first_cap_at_100: assert property ( // RULE_01
    CFG_ACK_OUT && addr_r == `SWX_OFF_AER_HDR |-> CFG_RDATA_OUT == `SWX_AER_HDR_VAL)
    else $error("first extended header wrong");
  chk_chain_above_ff: assert property ( // RULE_02
    CFG_ACK_OUT && addr_r == `SWX_OFF_VC_HDR |-> CFG_RDATA_OUT[31:20] > `SWX_EXT_BASE)
    else $error("capability pointer inside legacy header");
  chk_aer_hdr_fields: assert property ( // RULE_03
    CFG_ACK_OUT && addr_r == `SWX_OFF_AER_HDR
    |-> CFG_RDATA_OUT[31:20] == `SWX_NEXT_AER && CFG_RDATA_OUT[15:0] == 16'h0001)
    else $error("first header id or pointer wrong");
  chk_vc_arb_offset: assert property ( // RULE_04
    CFG_ACK_OUT && addr_r == `SWX_OFF_VC_CAP2 |-> CFG_RDATA_OUT[31:24] == 8'h03)
    else $error("channel arbitration table offset wrong");
  chk_ch1_port_arb: assert property ( // RULE_05
    CFG_ACK_OUT && addr_r == `SWX_OFF_R1_CAP |-> CFG_RDATA_OUT[31:24] == 8'h06)
    else $error("second channel port table offset wrong");
  chk_acs_hdr_fields: assert property ( // RULE_06
    CFG_ACK_OUT && addr_r == `SWX_OFF_ACS_HDR |-> CFG_RDATA_OUT == `SWX_ACS_HDR_VAL)
    else $error("access control header wrong");
  chk_ltr_write_read: assert property ( // RULE_07
    taken && CFG_WR_IN && wa == `SWX_OFF_LTR_LAT && CFG_BE_IN == 4'hF
    |=> ltr_r == ($past(CFG_WDATA_IN) & `SWX_LTR_WMASK))
    else $error("latency word write lost");
  chk_vid_write_ignored: assert property ( // RULE_08
    taken && CFG_WR_IN && wa == `SWX_OFF_VID && !VID_LOAD_IN |=> $stable(vid_r))
    else $error("vendor_identifier changed by config write");
  chk_vid_load_path: assert property ( // RULE_08
    VID_LOAD_IN |=> vid_r == $past(VID_LOAD_DATA_IN))
    else $error("vendor_identifier load lost");
  chk_reserved_zero: assert property ( // RULE_09
    CFG_ACK_OUT && addr_r == `SWX_OFF_AER_RSVD |-> CFG_RDATA_OUT == 32'h0000_0000)
    else $error("reserved offset read nonzero");
  chk_fatal_summary: assert property (
    |(ue_stat & ~ue_mask_r & ue_sev_r) |=> ERR_FATAL_OUT)
    else $error("fatal summary missed");
  chk_hlog_capture: assert property (log_take |=> hlog_r == $past(HDR_LOG_IN))
    else $error("header log not captured");
  chk_table_stale: assert property (wr && in_tbl |=> tbl_sts_r)
    else $error("table status not set by table write");

  cov_table_write_read: cover property (wr && in_tbl ##2 taken && !CFG_WR_IN && in_tbl);
  cov_vid_reload: cover property (VID_LOAD_IN ##[1:4] taken && wa == `SWX_OFF_VID);
  cov_fatal_error: cover property (ERR_FATAL_OUT);
  cov_status_clear: cover property (wr && wa == `SWX_OFF_UE_STAT && ue_stat != 32'h0000_0000);
  cov_table_status_clear: cover property (tbl_sts_r ##1 !tbl_sts_r);
endmodule
`default_nettype wire

// ### swx_host.sv
// host model issuing configuration accesses to the register bank
`timescale 1ns/1ns
`default_nettype none
module swx_host (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [31:0] rdata_in,
  output logic req_out,
  output logic wr_out,
  output logic [11:0] addr_out,
  output logic [3:0] be_out,
  output logic [31:0] wdata_out
);
  // idle bus at time zero
  initial begin
    req_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 12'h000;
    be_out = 4'h0;
    wdata_out = 32'h0000_0000;
  end

  // one access: drive after falling edge, hold until ack seen at a rising edge
  task automatic access(input logic w, input logic [11:0] a, input logic [3:0] b,
                        input logic [31:0] d, output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(negedge clk_in);
    req_out = 1'b1;
    wr_out = w;
    addr_out = a;
    be_out = b;
    wdata_out = d;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_in !== 1'b1 && n < 16);
    ok = ack_in;
    rd = rdata_in;
    @(negedge clk_in);
    // released lines show a changed pattern, not the old value
    req_out = 1'b0;
    wr_out = ~w;
    addr_out = ~a;
    be_out = ~b;
    wdata_out = ~d;
  endtask
endmodule
`default_nettype wire

// ### tb_swx_ecfg.sv
// self-checking bench of the extended config space bank
`timescale 1ns/1ns
`default_nettype none
module tb_swx_ecfg;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req, wr, ack;
  logic vld = 1'b0;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, ltr, rd, v, m;
  logic [15:0] vdat = 16'h0000;
  logic [31:0] ue_ev = 32'h0000_0000;
  logic [31:0] ce_ev = 32'h0000_0000;
  logic [127:0] hlog = 128'h0;
  logic [15:0] access_control_services;
  logic [7:0] egr;
  logic [3:0] lanes;
  logic fat, nfat, cor, ch1;
  logic ok;
  int err_count = 0;
  int n_tests = 0;
  int idx;
  logic [31:0] tbl [36];
  logic [11:0] hoff [5] = '{12'h100, 12'h140, 12'h20C, 12'h220, 12'h230};
  logic [11:0] hnxt [5] = '{12'h140, 12'h20C, 12'h220, 12'h000, 12'h000};
  logic [15:0] hid [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h000D, 16'h0018};
  logic [11:0] rsv [5] = '{12'h12C, 12'h168, 12'h200, 12'h21C, 12'h22C};

  always #2 clk = ~clk;

  swx_host u_host (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .req_out(req),
    .wr_out(wr), .addr_out(addr), .be_out(be), .wdata_out(wdata));

  swx_ecfg u_dut (.CLK_IN(clk), .NRST_IN(nrst), .CFG_REQ_IN(req), .CFG_WR_IN(wr),
    .CFG_ADDR_IN(addr), .CFG_BE_IN(be), .CFG_WDATA_IN(wdata), .CFG_ACK_OUT(ack),
    .CFG_RDATA_OUT(rdata), .VID_LOAD_IN(vld), .VID_LOAD_DATA_IN(vdat),
    .UE_EVENT_IN(ue_ev), .CE_EVENT_IN(ce_ev), .HDR_LOG_IN(hlog),
    .ERR_FATAL_OUT(fat), .ERR_NONFATAL_OUT(nfat), .ERR_COR_OUT(cor), .ACS_CTRL_OUT(access_control_services),
    .EGRESS_VEC_OUT(egr), .CH1_ENABLE_OUT(ch1), .LTR_LIMITS_OUT(ltr));

  // capability header word: next pointer, version 1, id
  function automatic logic [31:0] exp_hdr(input int i);
    return {hnxt[i], 4'h1, hid[i]};
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] b);
    for (int k = 0; k < 4; k++) begin
      if (b[k]) o[8*k +: 8] = n[8*k +: 8];
    end
    return o;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rw(input logic w, input logic [11:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    u_host.access(w, a, b, d, rd, ok);
    chk({31'h0, ok}, 32'h1);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #20000;
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    results();
  end

  // main sequence
  initial begin
    void'($urandom(32'hA3DC));
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    // header chain, read-only against random writes
    foreach (hoff[i]) begin
      rw(1'b1, hoff[i], 4'hF, $urandom());
      rw(1'b0, hoff[i], 4'hF, 32'h0);
      chk(rd, exp_hdr(i));
      chk({31'h0, rd[31:20] > 12'h0FF}, {31'h0, hnxt[i] != 12'h000});
    end
    // table offset fields
    rw(1'b0, 12'h148, 4'hF, 32'h0);
    chk({24'h0, rd[31:24]}, 32'h3);
    rw(1'b0, 12'h15C, 4'hF, 32'h0);
    chk({24'h0, rd[31:24]}, 32'h6);
    // vendor_identifier: reset value (arbitrary), write ignored, loads take effect
    rw(1'b1, 12'h000, 4'hF, $urandom());
    rw(1'b0, 12'h000, 4'hF, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h0000_1A2B);
    repeat (2) begin
      @(negedge clk);
      vdat = 16'($urandom());
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
      rw(1'b0, 12'h000, 4'hF, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, vdat});
    end
    // latency limits: full and single-lane writes
    m = 32'h1FFF_1FFF;
    v = $urandom();
    rw(1'b1, 12'h234, 4'hF, v);
    rw(1'b0, 12'h234, 4'hF, 32'h0);
    chk(rd, v & m);
    chk(ltr, v & m);
    rw(1'b1, 12'h234, 4'h1, ~v);
    v = merge(v & m, ~v, 4'h1) & m;
    chk(ltr, v);
    // reserved words read zero and writes leave no trace
    foreach (rsv[i]) begin
      rw(1'b1, rsv[i], 4'hF, $urandom());
      rw(1'b0, rsv[i], 4'hF, 32'h0);
      chk(rd, 32'h0);
    end
    chk(ltr, v);
    // error events: status, header log, summaries, severity, write-one clear
    @(negedge clk);
    ue_ev = 32'h0000_0010;
    ce_ev = 32'h0000_0001;
    hlog = {$urandom(), $urandom(), $urandom(), $urandom()};
    @(negedge clk);
    ue_ev = 32'h0000_0000;
    ce_ev = 32'h0000_0000;
    rw(1'b0, 12'h104, 4'hF, 32'h0);
    chk(rd, 32'h0000_0010);
    rw(1'b0, 12'h110, 4'hF, 32'h0);
    chk(rd, 32'h0000_0001);
    chk({29'h0, fat, nfat, cor}, 32'h3);
    for (int i = 0; i < 4; i++) begin
      rw(1'b0, 12'h11C + 12'(i * 4), 4'hF, 32'h0);
      chk(rd, hlog[32*i +: 32]);
    end
    rw(1'b1, 12'h10C, 4'hF, 32'h0000_0010);
    chk({29'h0, fat, nfat, cor}, 32'h5);
    rw(1'b1, 12'h104, 4'hF, 32'h0000_0010);
    rw(1'b1, 12'h110, 4'hF, 32'h0000_0001);
    chk({29'h0, fat, nfat, cor}, 32'h0);
    // access control, egress and channel enable words reach their outputs
    rw(1'b1, 12'h224, 4'hF, 32'hFFFF_FFFF);
    rw(1'b1, 12'h228, 4'hF, 32'hFFFF_FFFF);
    rw(1'b1, 12'h160, 4'hF, 32'h8000_0000);
    rw(1'b0, 12'h224, 4'hF, 32'h0);
    chk(rd, 32'h001F_001F);
    chk({access_control_services, egr, 7'h0, ch1}, 32'h001F_0701);
    // arbitration tables: reset zero, random byte-lane writes
    foreach (tbl[i]) tbl[i] = 32'h0;
    repeat (12) begin
      idx = $urandom_range(35, 0);
      lanes = 4'($urandom());
      v = $urandom();
      rw(1'b1, 12'h170 + 12'(idx * 4), lanes, v);
      tbl[idx] = merge(tbl[idx], v, lanes);
    end
    for (int i = 0; i < 36; i++) begin
      rw(1'b0, 12'h170 + 12'(i * 4), 4'hF, 32'h0);
      chk(rd, tbl[i]);
    end
    // table status set by table writes, cleared by the load command bit
    rw(1'b0, 12'h14C, 4'hF, 32'h0);
    chk(rd, 32'h0001_0000);
    rw(1'b1, 12'h14C, 4'hF, 32'h0000_0001);
    rw(1'b0, 12'h14C, 4'hF, 32'h0);
    chk(rd, 32'h0000_0001);
    results();
  end
endmodule
`default_nettype wire
